// [hw/ssr_pkg.sv]
// Shared constants and types of the system supervisor.
package ssr_pkg;

  // Clock and timing
  localparam int CLK_PERIOD_NS      = 10;
  localparam int POR_TIME_NS        = 10000;
  localparam int POR_CYCLES         = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MIN_PULSE_NS       = 100;
  localparam int MIN_PULSE_CYCLES   = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL       = 8'h00;
  localparam logic [7:0] REG_WARN_MASK  = 8'h04;
  localparam logic [7:0] REG_STATUS     = 8'h08;
  localparam logic [7:0] REG_WDG_CTRL   = 8'h0C;
  localparam logic [7:0] REG_WDG_RELOAD = 8'h10;
  localparam logic [7:0] REG_WDG_KICK   = 8'h14;
  localparam logic [7:0] REG_WDG_COUNT  = 8'h18;
  localparam logic [7:0] REG_PERIPH_RST = 8'h1C;

  // Field positions
  localparam int CTRL_LVD_OFF_BIT  = 0;
  localparam int CTRL_IO_BLOCK_BIT = 1;
  localparam int CTRL_SLEEP_BIT    = 2;
  localparam int STAT_WDG_BIT      = 0;
  localparam int STAT_SUPPLY_BIT   = 1;
  localparam int STAT_CWARN_BIT    = 2;
  localparam int STAT_IWARN_BIT    = 3;
  localparam int WCTL_EN_BIT       = 0;
  localparam int WCTL_MODE_BIT     = 1;
  localparam int WCTL_PRE_LSB      = 8;

  // Reset values
  localparam logic [15:0] WDG_RELOAD_RST = 16'hFFFF;
  localparam logic [31:0] BOOT_ADDR      = 32'h0000_0000;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Supervisor states
  typedef enum logic [1:0] {ST_GR, ST_SR, ST_RUN, ST_SLEEP} ssr_state_type;

endpackage

// [hw/ssr_sync.sv]
// Two-stage synchronizer for a group of asynchronous levels.
`timescale 1ns/1ps
`default_nettype none
module ssr_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             i_core_clk,
  input  wire logic             i_reset_n,
  // Levels
  input  wire logic [WIDTH-1:0] i_async,
  output var  logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_r;

  // Each bit passes two flops; only the second stage is read
  for (genvar g = 0; g < WIDTH; g++)
  begin : g_bit
    always_ff @(posedge i_core_clk or negedge i_reset_n)
    begin
      if (!i_reset_n)
      begin
        meta_r[g] <= 1'b0;
        o_sync[g] <= 1'b0;
      end
      else
      begin
        meta_r[g] <= i_async[g];
        o_sync[g] <= meta_r[g];
      end
    end
  end

endmodule
`default_nettype wire

// [hw/ssr_supervisor.sv]
// System supervisor: reset scope, cause, brown-out warning, sleep, watchdog.
// Contract
// - Sleep stops all clocks but real-time clock and disables oscillator pins.
// - Sleep exit by alarm or wake-up needs the real-time clock running.
// - Pin, low-voltage, power-up, debug reset, alarm or wake-up ends sleep.
// - Global reset clears everything; system reset keeps status register. Here both reset scopes keep status; only power-up clears it.
// - Core drop, I/O drop and power-up each cause global reset.
// - Watchdog, board pin and debug command each cause system reset.
// - Status records watchdog or supply cause; cleared only at power-up.
// - Core and I/O sag each raise an early warning interrupt.
// - Mask bits suppress brown-out warning interrupts.
// - Core supply drop always forces global reset.
// - Nonvolatile bit picks between the two I/O drop thresholds.
// - Control bit blocks the I/O low-voltage reset.
// - Detector disable stops warnings and I/O drop resets.
// - Watchdog is a 16-bit down-counter, watchdog or free-running.
// - Counter clocked from peripheral clock through 8-bit prescaler.
// - Watchdog mode: reaching terminal count without reload gives system reset.
// - Watchdog disabled after every reset until firmware enables it.
// - Board pin held low for minimum width causes system reset. Here the pin must stay low for P_PULSE_CYC + 1 cycles.
// - Board reset output low with same duration as power-on reset.
// - Power-up: reset held until supplies good, then power-on duration.
// - After reset the first fetch is from the flash base address.
// - Firmware can reset each peripheral individually at any time.
// - Sleep forces the PLL off and keeps the wake-up unit powered.
// - Only global resets reach the test access controllers.
//
// Added by the designer: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
module ssr_supervisor
  import ssr_pkg::*;
#(
  parameter int P_POR_CYCLES = POR_CYCLES,
  parameter int P_PULSE_CYC  = MIN_PULSE_CYCLES,
  parameter int N_PERIPH     = 8
) (
  // Clock and power-up reset
  input  wire logic                i_core_clk,
  input  wire logic                i_reset_n,
  // Supply comparators and configuration
  input  wire logic                i_core_drop,
  input  wire logic                i_core_warn,
  input  wire logic                i_io_drop_2v4,
  input  wire logic                i_io_drop_2v7,
  input  wire logic                i_io_warn,
  input  wire logic                i_io_level_sel,
  // Board, debug and wake sources
  input  wire logic                i_board_reset_input_n,
  input  wire logic                i_debug_mode,
  input  wire logic                i_debug_reset_cmd,
  input  wire logic                i_rtc_running,
  input  wire logic                i_rtc_alarm,
  input  wire logic                i_wakeup_in,
  input  wire logic                i_pclk_tick,
  // Reset and power outputs
  output var  logic                o_global_reset_n,
  output var  logic                o_system_reset_n,
  output var  logic                o_tap_reset_n,
  output var  logic                o_board_reset_drive_n,
  output var  logic [N_PERIPH-1:0] o_periph_reset_n,
  output var  logic                o_clocks_enable,
  output var  logic                o_osc_pins_enable,
  output var  logic                o_pll_force_off,
  output var  logic                o_wakeup_power,
  output var  logic                o_sleep_active,
  output var  logic                o_brownout_irq,
  output var  logic [31:0]         o_boot_addr,
  // AXI4-Lite slave
  input  wire logic [7:0]          i_s_axi_awaddr,
  input  wire logic                i_s_axi_awvalid,
  output logic                     o_s_axi_awready,
  input  wire logic [31:0]         i_s_axi_wdata,
  input  wire logic [3:0]          i_s_axi_wstrb,
  input  wire logic                i_s_axi_wvalid,
  output logic                     o_s_axi_wready,
  output var  logic [1:0]          o_s_axi_bresp,
  output var  logic                o_s_axi_bvalid,
  input  wire logic                i_s_axi_bready,
  input  wire logic [7:0]          i_s_axi_araddr,
  input  wire logic                i_s_axi_arvalid,
  output logic                     o_s_axi_arready,
  output var  logic [31:0]         o_s_axi_rdata,
  output var  logic [1:0]          o_s_axi_rresp,
  output var  logic                o_s_axi_rvalid,
  input  wire logic                i_s_axi_rready
);

  // Refuse parameters the 16-bit counters and 32-bit register cannot hold
  if (P_POR_CYCLES < 1 || P_POR_CYCLES > 65535 || P_PULSE_CYC < 1 || P_PULSE_CYC > 65535
      || N_PERIPH < 1 || N_PERIPH > 32)
  begin : g_bad_param
    $error("ssr_supervisor: parameter out of range");
  end

  localparam logic [15:0] POR_LOAD   = 16'(P_POR_CYCLES - 1);
  localparam logic [15:0] PULSE_LOAD = 16'(P_PULSE_CYC);

  ssr_state_type      state_r;
  logic [15:0]        hold_cnt_r;
  logic [15:0]        pin_cnt_r;
  logic [11:0]        sync_s;
  logic               core_drop_s, core_warn_s, io_2v4_s, io_2v7_s, io_warn_s, io_sel_s;
  logic               pin_low_s, dbg_mode_s, dbg_cmd_s, rtc_s, alarm_s, wake_s;
  logic               io_drop, io_drop_req, global_req, pin_valid, dbg_req, sys_req;
  logic               in_reset, wake_ok;
  logic               lvd_off_r, io_block_r, sleep_req_r;
  logic [1:0]         mask_r;
  logic [3:0]         status_r;
  logic               wdg_en_r, wdg_mode_r, wdg_to_r, kick;
  logic [7:0]         wdg_pre_r, wdg_pre_cnt_r;
  logic [15:0]        wdg_reload_r, wdg_cnt_r;
  logic [N_PERIPH-1:0] periph_rst_r;
  logic [7:0]         aw_addr_r, ar_addr_r;
  logic               aw_held_r, w_held_r;
  logic [31:0]        w_data_r, rd_data;
  logic [3:0]         w_strb_r;
  logic               wr_fire, wr_hit, rd_hit;

  // Pins and comparators pass two flops before use
  ssr_sync #(.WIDTH(12)) u_sync (
    .i_core_clk (i_core_clk),
    .i_reset_n  (i_reset_n),
    .i_async    ({i_core_drop, i_core_warn, i_io_drop_2v4, i_io_drop_2v7, i_io_warn,
                  i_io_level_sel, ~i_board_reset_input_n, i_debug_mode, i_debug_reset_cmd,
                  i_rtc_running, i_rtc_alarm, i_wakeup_in}),
    .o_sync     (sync_s)
  );
  assign {core_drop_s, core_warn_s, io_2v4_s, io_2v7_s, io_warn_s, io_sel_s,
          pin_low_s, dbg_mode_s, dbg_cmd_s, rtc_s, alarm_s, wake_s} = sync_s;

  // Reset request decode
  assign io_drop     = io_sel_s ? io_2v7_s : io_2v4_s;
  assign io_drop_req = io_drop && !lvd_off_r && !io_block_r;
  assign global_req  = core_drop_s || io_drop_req;
  assign pin_valid   = pin_low_s && (pin_cnt_r >= PULSE_LOAD);
  assign dbg_req     = dbg_cmd_s && dbg_mode_s;
  assign sys_req     = wdg_to_r || pin_valid || dbg_req;
  assign in_reset    = (state_r == ST_GR) || (state_r == ST_SR);
  assign wake_ok     = rtc_s && (alarm_s || wake_s);

  // Board pin low-time filter
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      pin_cnt_r <= 16'h0000;
    else if (!pin_low_s)
      pin_cnt_r <= 16'h0000;
    else if (pin_cnt_r < PULSE_LOAD)
      pin_cnt_r <= pin_cnt_r + 16'h0001;
  end

  // Reset and sleep sequencer
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state_r    <= ST_GR;
      hold_cnt_r <= POR_LOAD;
    end
    else if (global_req)
    begin
      state_r    <= ST_GR;
      hold_cnt_r <= POR_LOAD;
    end
    else if (sys_req)
    begin
      state_r    <= (state_r == ST_GR) ? ST_GR : ST_SR;
      hold_cnt_r <= POR_LOAD;
    end
    else
    begin
      case (state_r)
        ST_GR, ST_SR:
        begin
          if (hold_cnt_r != 16'h0000)
            hold_cnt_r <= hold_cnt_r - 16'h0001;
          else
            state_r <= ST_RUN;
        end
        ST_RUN:
          if (sleep_req_r)
            state_r <= ST_SLEEP;
        ST_SLEEP:
          if (wake_ok)
            state_r <= ST_RUN;
        default:
          state_r <= ST_GR;
      endcase
    end
  end

  // Registered reset, clock and power outputs
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_global_reset_n      <= 1'b0;
      o_system_reset_n      <= 1'b0;
      o_tap_reset_n         <= 1'b0;
      o_board_reset_drive_n <= 1'b0;
      o_clocks_enable       <= 1'b1;
      o_osc_pins_enable     <= 1'b1;
      o_pll_force_off       <= 1'b0;
      o_sleep_active        <= 1'b0;
      o_wakeup_power        <= 1'b1;
      o_boot_addr           <= BOOT_ADDR;
    end
    else
    begin
      o_global_reset_n      <= (state_r != ST_GR);
      o_system_reset_n      <= !in_reset;
      o_tap_reset_n         <= (state_r != ST_GR);
      o_board_reset_drive_n <= !in_reset;
      o_clocks_enable       <= (state_r != ST_SLEEP);
      o_osc_pins_enable     <= (state_r != ST_SLEEP);
      o_pll_force_off       <= (state_r == ST_SLEEP);
      o_sleep_active        <= (state_r == ST_SLEEP);
      o_wakeup_power        <= 1'b1;
      o_boot_addr           <= BOOT_ADDR;
    end
  end

  // Per-peripheral reset lines, firmware controlled
  assign o_periph_reset_n = ~periph_rst_r;

  // Write channel capture, address and data in either order
  assign o_s_axi_awready = !aw_held_r && !o_s_axi_bvalid;
  assign o_s_axi_wready  = !w_held_r && !o_s_axi_bvalid;
  assign wr_fire         = aw_held_r && w_held_r && !o_s_axi_bvalid;
  assign wr_hit          = (aw_addr_r[7:5] == 3'h0);
  assign kick            = wr_fire && (aw_addr_r[7:2] == REG_WDG_KICK[7:2]);
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      aw_held_r      <= 1'b0;
      w_held_r       <= 1'b0;
      aw_addr_r      <= 8'h00;
      w_data_r       <= 32'h0000_0000;
      w_strb_r       <= 4'h0;
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp  <= RESP_OKAY;
    end
    else
    begin
      if (i_s_axi_awvalid && o_s_axi_awready)
      begin
        aw_held_r <= 1'b1;
        aw_addr_r <= i_s_axi_awaddr;
      end
      if (i_s_axi_wvalid && o_s_axi_wready)
      begin
        w_held_r <= 1'b1;
        w_data_r <= i_s_axi_wdata;
        w_strb_r <= i_s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_held_r      <= 1'b0;
        w_held_r       <= 1'b0;
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (o_s_axi_bvalid && i_s_axi_bready)
        o_s_axi_bvalid <= 1'b0;
    end
  end

  // Control registers, cleared by either reset scope
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      lvd_off_r    <= 1'b0;
      io_block_r   <= 1'b0;
      sleep_req_r  <= 1'b0;
      mask_r       <= 2'h0;
      wdg_en_r     <= 1'b0;
      wdg_mode_r   <= 1'b0;
      wdg_pre_r    <= 8'h00;
      wdg_reload_r <= WDG_RELOAD_RST;
      periph_rst_r <= '0;
    end
    else if (in_reset)
    begin
      lvd_off_r    <= 1'b0;
      io_block_r   <= 1'b0;
      sleep_req_r  <= 1'b0;
      mask_r       <= 2'h0;
      wdg_en_r     <= 1'b0;
      wdg_mode_r   <= 1'b0;
      wdg_pre_r    <= 8'h00;
      wdg_reload_r <= WDG_RELOAD_RST;
      periph_rst_r <= '0;
    end
    else
    begin
      sleep_req_r <= wr_fire && w_strb_r[0] && (aw_addr_r == REG_CTRL)
                     && w_data_r[CTRL_SLEEP_BIT];
      if (wr_fire && w_strb_r[0] && aw_addr_r == REG_CTRL)
      begin
        lvd_off_r  <= w_data_r[CTRL_LVD_OFF_BIT];
        io_block_r <= w_data_r[CTRL_IO_BLOCK_BIT];
      end
      if (wr_fire && w_strb_r[0] && aw_addr_r == REG_WARN_MASK)
        mask_r <= w_data_r[1:0];
      if (wr_fire && aw_addr_r == REG_WDG_CTRL)
      begin
        if (w_strb_r[0])
        begin
          wdg_en_r   <= w_data_r[WCTL_EN_BIT];
          wdg_mode_r <= w_data_r[WCTL_MODE_BIT];
        end
        if (w_strb_r[1])
          wdg_pre_r <= w_data_r[WCTL_PRE_LSB +: 8];
      end
      if (wr_fire && aw_addr_r == REG_WDG_RELOAD && w_strb_r[1:0] == 2'h3)
        wdg_reload_r <= w_data_r[15:0];
      if (wr_fire && w_strb_r[0] && aw_addr_r == REG_PERIPH_RST)
        periph_rst_r <= w_data_r[N_PERIPH-1:0];
    end
  end

  // Cause bits cleared only by power-up, warning bits also by write-one; set wins over clear
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      status_r <= 4'h0;
    else
    begin
      if (wr_fire && w_strb_r[0] && aw_addr_r == REG_STATUS)
      begin
        status_r[STAT_CWARN_BIT] <= status_r[STAT_CWARN_BIT] & ~w_data_r[STAT_CWARN_BIT];
        status_r[STAT_IWARN_BIT] <= status_r[STAT_IWARN_BIT] & ~w_data_r[STAT_IWARN_BIT];
      end
      if (global_req)
        status_r[STAT_SUPPLY_BIT] <= 1'b1;
      else if (wdg_to_r)
        status_r[STAT_WDG_BIT] <= 1'b1;
      if (core_warn_s && !lvd_off_r)
        status_r[STAT_CWARN_BIT] <= 1'b1;
      if (io_warn_s && !lvd_off_r)
        status_r[STAT_IWARN_BIT] <= 1'b1;
    end
  end

  // Brown-out warning interrupt, gated by mask bits
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_brownout_irq <= 1'b0;
    else
      o_brownout_irq <= |(status_r[STAT_IWARN_BIT:STAT_CWARN_BIT] & ~mask_r);
  end

  // Watchdog prescaler and 16-bit down-counter
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      wdg_pre_cnt_r <= 8'h00;
      wdg_cnt_r     <= WDG_RELOAD_RST;
      wdg_to_r      <= 1'b0;
    end
    else if (in_reset)
    begin
      wdg_pre_cnt_r <= 8'h00;
      wdg_cnt_r     <= WDG_RELOAD_RST;
      wdg_to_r      <= 1'b0;
    end
    else
    begin
      wdg_to_r <= 1'b0;
      if (kick)
      begin
        wdg_cnt_r     <= wdg_reload_r;
        wdg_pre_cnt_r <= 8'h00;
      end
      else if (wdg_en_r && i_pclk_tick)
      begin
        if (wdg_pre_cnt_r == wdg_pre_r)
        begin
          wdg_pre_cnt_r <= 8'h00;
          if (wdg_cnt_r == 16'h0000)
          begin
            wdg_cnt_r <= wdg_reload_r;
            wdg_to_r  <= wdg_mode_r;
          end
          else
            wdg_cnt_r <= wdg_cnt_r - 16'h0001;
        end
        else
          wdg_pre_cnt_r <= wdg_pre_cnt_r + 8'h01;
      end
    end
  end

  // Read decode
  assign rd_hit = (ar_addr_r[7:5] == 3'h0);
  always_comb
  begin
    rd_data = 32'h0000_0000;
    case (ar_addr_r)
      REG_CTRL:       rd_data = {30'h0, io_block_r, lvd_off_r};
      REG_WARN_MASK:  rd_data = {30'h0, mask_r};
      REG_STATUS:     rd_data = {28'h0, status_r};
      REG_WDG_CTRL:   rd_data = {16'h0, wdg_pre_r, 6'h0, wdg_mode_r, wdg_en_r};
      REG_WDG_RELOAD: rd_data = {16'h0, wdg_reload_r};
      REG_WDG_COUNT:  rd_data = {16'h0, wdg_cnt_r};
      REG_PERIPH_RST: rd_data = 32'(periph_rst_r);
      default:        rd_data = 32'h0000_0000;
    endcase
  end

  // Read channel: address taken, answer one cycle later from a flop
  logic ar_pend_r;
  assign o_s_axi_arready = !ar_pend_r && !o_s_axi_rvalid;
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      ar_pend_r      <= 1'b0;
      ar_addr_r      <= 8'h00;
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata  <= 32'h0000_0000;
      o_s_axi_rresp  <= RESP_OKAY;
    end
    else if (ar_pend_r)
    begin
      ar_pend_r      <= 1'b0;
      o_s_axi_rvalid <= 1'b1;
      o_s_axi_rdata  <= rd_data;
      o_s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (i_s_axi_arvalid && o_s_axi_arready)
    begin
      ar_pend_r <= 1'b1;
      ar_addr_r <= i_s_axi_araddr;
    end
    else if (o_s_axi_rvalid && i_s_axi_rready)
      o_s_axi_rvalid <= 1'b0;
  end

  // Checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);

  sequence s_sleep_blocked;
    (state_r == ST_SLEEP) && !rtc_s && !global_req && !sys_req;
  endsequence
  sequence s_wdg_fire;
    wdg_to_r && !global_req && (state_r != ST_GR);
  endsequence

  AST_CORE_DROP_GLOBAL: assert property (core_drop_s |=>
    state_r == ST_GR ##1 !o_global_reset_n)
    else $error("core drop did not give global reset");
  AST_POR_HOLD: assert property (global_req |=>
    state_r == ST_GR && hold_cnt_r == POR_LOAD)
    else $error("power-on hold not reloaded");
  AST_TAP_GLOBAL_ONLY: assert property (state_r == ST_SR |=> o_tap_reset_n)
    else $error("system reset reached test access reset");
  AST_BOARD_OUT: assert property (o_board_reset_drive_n == !$past(in_reset)
    && o_board_reset_drive_n == o_system_reset_n)
    else $error("board reset output differs from system reset");
  AST_SLEEP_CLOCKS: assert property (state_r == ST_SLEEP |=>
    !o_clocks_enable && !o_osc_pins_enable && o_pll_force_off)
    else $error("clocks still on in sleep");
  AST_SLEEP_NEEDS_RTC: assert property (s_sleep_blocked |=> state_r == ST_SLEEP)
    else $error("sleep left without real-time clock");
  AST_WAKE: assert property ((state_r == ST_SLEEP) && wake_ok && !global_req && !sys_req
    |=> state_r == ST_RUN)
    else $error("alarm or wake-up did not end sleep");
  AST_WDG_OFF_AFTER_RESET: assert property (in_reset |=> !wdg_en_r)
    else $error("watchdog enabled during reset");
  AST_WDG_TIMEOUT: assert property (s_wdg_fire |=>
    state_r == ST_SR ##1 status_r[STAT_WDG_BIT] && !o_system_reset_n)
    else $error("watchdog timeout without system reset");
  AST_IRQ_MASK: assert property ((mask_r == 2'h3) [*2] |-> !o_brownout_irq)
    else $error("masked warning raised interrupt");

endmodule
`default_nettype wire

// [tb/ssr_brd.sv]
// Board pin and debug controller model for the supervisor bench.
`timescale 1ns/1ps
`default_nettype none
module ssr_brd (
  // Clock
  input  wire logic i_core_clk,
  // Board and debug lines
  output var  logic o_board_reset_input_n,
  output var  logic o_debug_mode,
  output var  logic o_debug_reset_cmd
);
  // Pull-up idle level, debug inactive
  initial
  begin
    o_board_reset_input_n = 1'b1;
    o_debug_mode = 1'b0;
    o_debug_reset_cmd = 1'b0;
  end
  // Hold the pin low for n cycles
  task automatic press(input int n);
    @(posedge i_core_clk);
    o_board_reset_input_n <= 1'b0;
    repeat (n) @(posedge i_core_clk);
    o_board_reset_input_n <= 1'b1;
  endtask
  // Reset command, issued only in debug mode
  task automatic debug_cmd();
    @(posedge i_core_clk);
    o_debug_mode <= 1'b1;
    o_debug_reset_cmd <= 1'b1;
    repeat (4) @(posedge i_core_clk);
    o_debug_reset_cmd <= 1'b0;
    o_debug_mode <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench of the system supervisor.
`timescale 1ns/1ps
`default_nettype none
module tb
  import ssr_pkg::*;
;
  logic i_core_clk = 0, i_reset_n = 0, i_core_drop = 0, i_core_warn = 0, i_io_warn = 0;
  logic i_io_drop_2v4 = 0, i_io_drop_2v7 = 0, i_io_level_sel = 0, i_rtc_running = 0;
  logic i_rtc_alarm = 0, i_wakeup_in = 0, i_pclk_tick = 0, i_s_axi_awvalid = 0;
  logic i_s_axi_wvalid = 0, i_s_axi_bready = 0, i_s_axi_arvalid = 0, i_s_axi_rready = 0;
  logic i_board_reset_input_n, i_debug_mode, i_debug_reset_cmd, o_sleep_active;
  logic o_global_reset_n, o_system_reset_n, o_tap_reset_n, o_board_reset_drive_n;
  logic o_clocks_enable, o_osc_pins_enable, o_pll_force_off, o_wakeup_power, o_brownout_irq;
  logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
  logic [7:0]  i_s_axi_awaddr = 0, i_s_axi_araddr = 0, o_periph_reset_n;
  logic [31:0] i_s_axi_wdata = 0, o_s_axi_rdata, o_boot_addr, rd_v, v;
  logic [3:0]  i_s_axi_wstrb = 4'hF;
  logic [1:0]  o_s_axi_bresp, o_s_axi_rresp, rs;
  int          num_errors = 0, cmp_count = 0;
  ssr_supervisor #(.P_POR_CYCLES(8), .P_PULSE_CYC(2), .N_PERIPH(8)) DUT (.*);
  ssr_brd brd (.i_core_clk(i_core_clk), .o_board_reset_input_n(i_board_reset_input_n),
    .o_debug_mode(i_debug_mode), .o_debug_reset_cmd(i_debug_reset_cmd));
  // Clock and random peripheral ticks
  always #5 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) i_pclk_tick <= 1'($urandom_range(0, 1));
  // Compare one value
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Bus write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    i_s_axi_awaddr <= a;
    i_s_axi_wdata <= d;
    i_s_axi_awvalid <= 1'b1;
    i_s_axi_wvalid <= 1'b1;
    i_s_axi_bready <= 1'b1;
    do @(negedge i_core_clk); while (!(o_s_axi_awready && o_s_axi_wready));
    @(posedge i_core_clk);
    i_s_axi_awvalid <= 1'b0;
    i_s_axi_wvalid <= 1'b0;
    do @(negedge i_core_clk); while (o_s_axi_bvalid !== 1'b1);
    rs = o_s_axi_bresp;
    @(posedge i_core_clk);
    i_s_axi_bready <= 1'b0;
  endtask
  // Bus read into rd_v and rs
  task automatic rd(input logic [7:0] a);
    @(posedge i_core_clk);
    i_s_axi_araddr <= a;
    i_s_axi_arvalid <= 1'b1;
    i_s_axi_rready <= 1'b1;
    do @(negedge i_core_clk); while (o_s_axi_arready !== 1'b1);
    @(posedge i_core_clk);
    i_s_axi_arvalid <= 1'b0;
    do @(negedge i_core_clk); while (o_s_axi_rvalid !== 1'b1);
    rd_v = o_s_axi_rdata;
    rs = o_s_axi_rresp;
    @(posedge i_core_clk);
    i_s_axi_rready <= 1'b0;
  endtask
  // Bounded wait for the system reset level
  task automatic till(input logic l);
    int n;
    n = 0;
    while (o_system_reset_n !== l && n < 300)
    begin
      @(negedge i_core_clk);
      n++;
    end
    chk(o_board_reset_drive_n, l);
  endtask
  // Verdict
  task automatic complete_run();
    $display("checks %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    void'($urandom(32'h150F));
    repeat (8) @(posedge i_core_clk);
    i_reset_n <= 1'b1;
    till(1'b1);
    chk(o_boot_addr, BOOT_ADDR);
    rd(REG_WDG_RELOAD);
    chk(rd_v, 32'(WDG_RELOAD_RST));
    rd(8'h20);
    chk(32'(rs), 32'(RESP_SLVERR));
    v = $urandom;
    wr(REG_PERIPH_RST, v);
    chk(32'(rs), 32'(RESP_OKAY));
    chk(o_periph_reset_n, 8'(~v[7:0]));
    wr(8'h24, v);
    chk(32'(rs), 32'(RESP_SLVERR));
    wr(REG_PERIPH_RST, 32'h0);
    brd.press(2);
    repeat (6) @(posedge i_core_clk);
    chk(o_system_reset_n, 1'b1);
    brd.press(3);
    till(1'b0);
    chk({o_global_reset_n, o_tap_reset_n}, 2'h3);
    till(1'b1);
    brd.debug_cmd();
    till(1'b0);
    till(1'b1);
    wr(REG_WDG_RELOAD, $urandom_range(3, 30));
    wr(REG_WDG_CTRL, 32'h3 | ($urandom_range(0, 2) << 8));
    wr(REG_WDG_KICK, 32'h0);
    till(1'b0);
    till(1'b1);
    rd(REG_WDG_CTRL);
    chk(rd_v, 32'h0);
    rd(REG_STATUS);
    chk(rd_v, 32'h1);
    i_core_drop <= 1'b1;
    repeat (3) @(posedge i_core_clk);
    i_core_drop <= 1'b0;
    till(1'b0);
    chk({o_global_reset_n, o_tap_reset_n}, 2'h0);
    till(1'b1);
    rd(REG_STATUS);
    chk(rd_v, 32'h3);
    wr(REG_WARN_MASK, 32'h2);
    i_io_warn <= 1'b1;
    repeat (4) @(posedge i_core_clk);
    chk(o_brownout_irq, 1'b0);
    wr(REG_WARN_MASK, 32'h0);
    repeat (3) @(posedge i_core_clk);
    chk(o_brownout_irq, 1'b1);
    wr(REG_CTRL, 32'h4);
    repeat (4) @(posedge i_core_clk);
    chk({o_sleep_active, o_clocks_enable, o_osc_pins_enable, o_pll_force_off,
      o_wakeup_power}, 5'h13);
    i_rtc_alarm <= 1'b1;
    repeat (6) @(posedge i_core_clk);
    chk(o_sleep_active, 1'b1);
    i_rtc_running <= 1'b1;
    repeat (6) @(posedge i_core_clk);
    chk(o_sleep_active, 1'b0);
    // Second sleep, left by the wake-up unit input
    i_rtc_alarm <= 1'b0;
    wr(REG_CTRL, 32'h4);
    repeat (3) @(posedge i_core_clk);
    chk(o_sleep_active, 1'b1);
    i_wakeup_in <= 1'b1;
    repeat (6) @(posedge i_core_clk);
    chk(o_sleep_active, 1'b0);
    i_wakeup_in <= 1'b0;
    // I/O drop: level select, block bit, then an unblocked drop
    i_io_level_sel <= 1'b1;
    i_io_drop_2v4  <= 1'b1;
    repeat (6) @(posedge i_core_clk);
    chk(o_system_reset_n, 1'b1);
    wr(REG_CTRL, 32'h2);
    i_io_drop_2v7 <= 1'b1;
    repeat (6) @(posedge i_core_clk);
    chk(o_system_reset_n, 1'b1);
    wr(REG_CTRL, 32'h0);
    till(1'b0);
    chk(o_tap_reset_n, 1'b0);
    @(posedge i_core_clk);
    i_io_drop_2v7 <= 1'b0;
    till(1'b1);
    // Detector off: no I/O drop reset, no new warning; core drop still resets
    wr(REG_CTRL, 32'h1);
    i_io_drop_2v7 <= 1'b1;
    i_core_warn   <= 1'b1;
    repeat (6) @(posedge i_core_clk);
    chk(o_system_reset_n, 1'b1);
    rd(REG_STATUS);
    chk(rd_v, 32'hB);
    i_core_drop   <= 1'b1;
    i_io_drop_2v7 <= 1'b0;
    repeat (3) @(posedge i_core_clk);
    i_core_drop <= 1'b0;
    i_core_warn <= 1'b0;
    i_io_warn   <= 1'b0;
    till(1'b0);
    till(1'b1);
    // Free-running mode wraps without a reset
    wr(REG_WDG_RELOAD, 32'h5);
    wr(REG_WDG_CTRL, 32'h1);
    wr(REG_WDG_KICK, 32'h0);
    repeat (100) @(posedge i_core_clk);
    chk(o_system_reset_n, 1'b1);
    rd(REG_WDG_COUNT);
    chk(32'(rd_v <= 32'h5), 32'h1);
    // Power-up reset alone clears the cause bits
    i_reset_n <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    i_reset_n <= 1'b1;
    till(1'b1);
    rd(REG_STATUS);
    chk(rd_v, 32'h0);
    complete_run();
  end
  // Watchdog against a hang
  initial
  begin
    #100000;
    num_errors++;
    complete_run();
  end
endmodule
`default_nettype wire
